// >>> inc/pxm_defs.vh
// register map, reset values and field positions of the port block
`ifndef PXM_DEFS_VH
`define PXM_DEFS_VH
// register addresses
`define PXM_ADR_P0_LATCH     8'h80
`define PXM_ADR_P1_LATCH     8'h90
`define PXM_ADR_P0_DRIVE     8'hA4
`define PXM_ADR_P1_DRIVE     8'hA5
`define PXM_ADR_P0_OVERV     8'hB0
`define PXM_ADR_P1_MASK      8'hBF
`define PXM_ADR_P0_MASK      8'hC7
`define PXM_ADR_P1_VALUE     8'hCF
`define PXM_ADR_P0_SKIP      8'hD4
`define PXM_ADR_P1_SKIP      8'hD5
`define PXM_ADR_P0_VALUE     8'hD7
`define PXM_ADR_ROUTE_B      8'hE2
`define PXM_ADR_P0_KIND      8'hF1
`define PXM_ADR_P1_KIND      8'hF2
// reset values
`define PXM_RST_LATCH        8'hFF
`define PXM_RST_DRIVE        8'h00
`define PXM_RST_OVERV        8'h00
`define PXM_RST_MASK         8'h00
`define PXM_RST_SKIP         8'h00
`define PXM_RST_VALUE        8'hFF
`define PXM_RST_ROUTE_B      8'h00
`define PXM_RST_KIND         8'hFF
// route_matrix_control_b fields
`define PXM_BIT_WPU_DIS      7
`define PXM_BIT_XBAR_EN      6
`define PXM_BIT_T1_EN        5
`define PXM_BIT_T0_EN        4
`define PXM_BIT_ECI_EN       3
`define PXM_CNT_MSB          2
`define PXM_CNT_LSB          0
`define PXM_CNT_MAX          3'h6
`endif

// >>> hdl/pxm_port_core.v
// port data latches, pin modes, second crossbar register and port match
//
// What this block does
// - weak pullups on unless disabled, analog or driving
// - route enable bit turns crossbar on
// - timer and counter clock routing enables
// - channel count routes channels, 111 reserved
// - written port value held in latch
// - plain port read returns pin levels
// - read-modify-write reads the latch instead
// - ports writable by byte and bit
// - masked pins differing from value raise match
// - match requests interrupt and wakes oscillator
// - mask zero excludes pin from match
// - latch zero low, one high or open
// - analog pins read as zero
// - analog pin: no pullup, driver, receiver
// - output mode ignored for analog pins
// - two-wire bus pins always open-drain
// - skip bits make crossbar pass pins
// - port 0 overdrive mode per pin
// - crossbar off disables all output drivers
`include "pxm_defs.vh"

module pxm_port_core #(
   parameter NPIN = 16                          // two ports of eight pins
) (
   // clock and reset
   input  wire              i_ref_clk,
   input  wire              i_rst_b,
   // special function register access
   input  wire [7:0]        i_sfr_addr,         // register address
   input  wire              i_sfr_wr,           // write strobe
   input  wire [7:0]        i_sfr_wdata,        // byte write data
   input  wire              i_sfr_bit_wr,       // single bit write of port latch
   input  wire [2:0]        i_sfr_bit_sel,      // bit number for bit write
   input  wire              i_sfr_bit_val,      // bit value for bit write
   input  wire              i_sfr_rd,           // read strobe
   input  wire              i_sfr_rmw,          // read is part of read-modify-write
   output reg  [7:0]        o_sfr_rdata,        // read data, valid cycle after strobe
   // pins, port 1 in upper byte
   input  wire [NPIN-1:0]   i_pin,              // pad receiver levels
   output reg  [NPIN-1:0]   o_pin_out,          // pad output level
   output reg  [NPIN-1:0]   o_pin_oe,           // pad driver enable
   output reg  [NPIN-1:0]   o_pin_pullup_en,    // weak pullup enable
   output reg  [NPIN-1:0]   o_pin_digital_en,   // digital receiver enable
   output wire [7:0]        o_p0_hiz_overdrive, // port 0 overdrive mode
   // crossbar side
   input  wire [NPIN-1:0]   i_xbar_claim,       // pin given to a peripheral
   input  wire [NPIN-1:0]   i_xbar_data,        // peripheral output level
   input  wire [NPIN-1:0]   i_xbar_two_wire,    // pin carries two-wire bus line
   output wire [NPIN-1:0]   o_route_skip,       // pins the decoder must pass over
   output wire              o_route_matrix_enable,
   output wire              o_second_timer_input_route_enable,
   output wire              o_first_timer_input_route_enable,
   output wire              o_counter_clock_input_route_enable,
   output reg  [5:0]        o_compare_channel_route, // channel n routed
   // match event
   input  wire              i_match_interrupt_enable, // enable bit held elsewhere
   input  wire              i_match_pending_clear,    // clear pending flag
   output reg               o_port_match,             // mismatch level
   output reg               o_match_pending,          // sticky pending flag
   output wire              o_match_irq,              // interrupt request
   output wire              o_osc_wake                // suspend wake request
);

   // configuration registers
   reg  [NPIN-1:0] latch_ff;     // port output latches
   reg  [NPIN-1:0] drive_ff;     // 1 push-pull, 0 open-drain
   reg  [NPIN-1:0] kind_ff;      // 1 digital, 0 analog
   reg  [NPIN-1:0] skip_ff;      // crossbar skip bits
   reg  [NPIN-1:0] mask_ff;      // compare masks
   reg  [NPIN-1:0] value_ff;     // compare values
   reg  [7:0]      overv_ff;     // port 0 overdrive mode
   reg  [7:0]      route_ff;     // route_matrix_control_b
   // pin synchronisers
   reg  [NPIN-1:0] sync1_ff;     // first stage, read only by second
   reg  [NPIN-1:0] sync2_ff;
   reg  [NPIN-1:0] sync3_ff;
   reg  [NPIN-1:0] pin_ff;       // accepted pin level
   reg             match_d_ff;   // match level one cycle back

   wire [NPIN-1:0] pin_read;     // level seen by reads and compare
   wire            mism;         // combined mismatch
   reg  [7:0]      nxt_rdata;
   reg  [NPIN-1:0] nxt_out;
   reg  [NPIN-1:0] nxt_oe;
   reg  [NPIN-1:0] nxt_pu;
   integer         k;            // synchroniser loop index
   // each process owns its loop index so no variable has two drivers
   integer         kp;           // pad control loop index
   integer         kc;           // channel route loop index

   // byte select of a 16 bit register pair by port
   function [7:0] pxm_byte;
      input [15:0] v;
      input        hi;
      begin
         pxm_byte = hi ? v[15:8] : v[7:0];
      end
   endfunction

   // latch update for byte or bit write
   function [7:0] pxm_wr_byte;
      input [7:0] old;
      input       bitw;
      input [2:0] sel;
      input       bval;
      input [7:0] data;
      reg   [7:0] tmp;
      begin
         tmp = old;
         tmp[sel] = bval;
         pxm_wr_byte = bitw ? tmp : data;
      end
   endfunction

   wire wr_p0 = (i_sfr_wr | i_sfr_bit_wr) & (i_sfr_addr == `PXM_ADR_P0_LATCH);
   wire wr_p1 = (i_sfr_wr | i_sfr_bit_wr) & (i_sfr_addr == `PXM_ADR_P1_LATCH);

   // register writes; latches take byte or bit writes
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         latch_ff <= {`PXM_RST_LATCH, `PXM_RST_LATCH};
         drive_ff <= {`PXM_RST_DRIVE, `PXM_RST_DRIVE};
         kind_ff  <= {`PXM_RST_KIND, `PXM_RST_KIND};
         skip_ff  <= {`PXM_RST_SKIP, `PXM_RST_SKIP};
         mask_ff  <= {`PXM_RST_MASK, `PXM_RST_MASK};
         value_ff <= {`PXM_RST_VALUE, `PXM_RST_VALUE};
         overv_ff <= `PXM_RST_OVERV;
         route_ff <= `PXM_RST_ROUTE_B;
      end else begin
         if (wr_p0) begin
            latch_ff[7:0] <= pxm_wr_byte(latch_ff[7:0], i_sfr_bit_wr, i_sfr_bit_sel,
                                         i_sfr_bit_val, i_sfr_wdata);
         end
         if (wr_p1) begin
            latch_ff[15:8] <= pxm_wr_byte(latch_ff[15:8], i_sfr_bit_wr, i_sfr_bit_sel,
                                          i_sfr_bit_val, i_sfr_wdata);
         end
         if (i_sfr_wr) begin
            case (i_sfr_addr)
               `PXM_ADR_P0_DRIVE: drive_ff[7:0]  <= i_sfr_wdata;
               `PXM_ADR_P1_DRIVE: drive_ff[15:8] <= i_sfr_wdata;
               `PXM_ADR_P0_KIND:  kind_ff[7:0]   <= i_sfr_wdata;
               `PXM_ADR_P1_KIND:  kind_ff[15:8]  <= i_sfr_wdata;
               `PXM_ADR_P0_SKIP:  skip_ff[7:0]   <= i_sfr_wdata;
               `PXM_ADR_P1_SKIP:  skip_ff[15:8]  <= i_sfr_wdata;
               `PXM_ADR_P0_MASK:  mask_ff[7:0]   <= i_sfr_wdata;
               `PXM_ADR_P1_MASK:  mask_ff[15:8]  <= i_sfr_wdata;
               `PXM_ADR_P0_VALUE: value_ff[7:0]  <= i_sfr_wdata;
               `PXM_ADR_P1_VALUE: value_ff[15:8] <= i_sfr_wdata;
               `PXM_ADR_P0_OVERV: overv_ff       <= i_sfr_wdata;
               `PXM_ADR_ROUTE_B:  route_ff       <= i_sfr_wdata;
               default: ;                       // unmapped: write ignored
            endcase
         end
      end
   end

   // three stage synchroniser; accept a level once stages two and three agree
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_ff <= {NPIN{1'b0}};
         sync2_ff <= {NPIN{1'b0}};
         sync3_ff <= {NPIN{1'b0}};
         pin_ff   <= {NPIN{1'b0}};
      end else begin
         sync1_ff <= i_pin;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         for (k = 0; k < NPIN; k = k + 1) begin
            if (sync2_ff[k] == sync3_ff[k]) begin
               pin_ff[k] <= sync3_ff[k];
            end
         end
      end
   end

   // analog pins have no receiver and read as zero
   assign pin_read = pin_ff & kind_ff;

   // read mux; registered so data is stable a cycle after the strobe
   always @* begin
      nxt_rdata = o_sfr_rdata;
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            // rmw reads the latch so open-drain highs held low are not lost
            `PXM_ADR_P0_LATCH: nxt_rdata = i_sfr_rmw ? latch_ff[7:0]
                                                     : pin_read[7:0];
            `PXM_ADR_P1_LATCH: nxt_rdata = i_sfr_rmw ? latch_ff[15:8]
                                                     : pin_read[15:8];
            `PXM_ADR_P0_DRIVE: nxt_rdata = pxm_byte(drive_ff, 1'b0);
            `PXM_ADR_P1_DRIVE: nxt_rdata = pxm_byte(drive_ff, 1'b1);
            `PXM_ADR_P0_KIND:  nxt_rdata = pxm_byte(kind_ff, 1'b0);
            `PXM_ADR_P1_KIND:  nxt_rdata = pxm_byte(kind_ff, 1'b1);
            `PXM_ADR_P0_SKIP:  nxt_rdata = pxm_byte(skip_ff, 1'b0);
            `PXM_ADR_P1_SKIP:  nxt_rdata = pxm_byte(skip_ff, 1'b1);
            `PXM_ADR_P0_MASK:  nxt_rdata = pxm_byte(mask_ff, 1'b0);
            `PXM_ADR_P1_MASK:  nxt_rdata = pxm_byte(mask_ff, 1'b1);
            `PXM_ADR_P0_VALUE: nxt_rdata = pxm_byte(value_ff, 1'b0);
            `PXM_ADR_P1_VALUE: nxt_rdata = pxm_byte(value_ff, 1'b1);
            `PXM_ADR_P0_OVERV: nxt_rdata = overv_ff;
            `PXM_ADR_ROUTE_B:  nxt_rdata = route_ff;
            default:           nxt_rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end

   // pad control per pin
   always @* begin
      nxt_out = {NPIN{1'b0}};
      nxt_oe  = {NPIN{1'b0}};
      nxt_pu  = {NPIN{1'b0}};
      for (kp = 0; kp < NPIN; kp = kp + 1) begin
         // claimed pins carry the peripheral level, others the latch
         nxt_out[kp] = i_xbar_claim[kp] ? i_xbar_data[kp] : latch_ff[kp];
         // low driven when crossbar on and pin digital; high only in push-pull and never on two-wire lines
         nxt_oe[kp] = route_ff[`PXM_BIT_XBAR_EN] & kind_ff[kp] &
                      (~nxt_out[kp] |
                       (drive_ff[kp] & ~i_xbar_two_wire[kp]));
         // pullup off when disabled, analog, or actively driving
         nxt_pu[kp] = ~route_ff[`PXM_BIT_WPU_DIS] & kind_ff[kp] & ~nxt_oe[kp];
      end
   end

   // mismatch on either port under mask
   assign mism = |((pin_read ^ value_ff) & mask_ff);

   // registered outputs and match pending flag
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sfr_rdata      <= 8'h00;
         o_pin_out        <= {NPIN{1'b0}};
         o_pin_oe         <= {NPIN{1'b0}};
         o_pin_pullup_en  <= {NPIN{1'b0}};
         o_pin_digital_en <= {NPIN{1'b0}};
         o_port_match     <= 1'b0;
         match_d_ff       <= 1'b0;
         o_match_pending  <= 1'b0;
      end else begin
         o_sfr_rdata      <= nxt_rdata;
         o_pin_out        <= nxt_out;
         o_pin_oe         <= nxt_oe;
         o_pin_pullup_en  <= nxt_pu;
         o_pin_digital_en <= kind_ff;
         o_port_match     <= mism;
         match_d_ff       <= o_port_match;
         // a new edge wins over a clear in the same cycle
         if (o_port_match & ~match_d_ff) begin
            o_match_pending <= 1'b1;
         end else if (i_match_pending_clear) begin
            o_match_pending <= 1'b0;
         end
      end
   end

   // channel count to per-channel mask; reserved code routes none
   always @* begin
      o_compare_channel_route = 6'h00;
      for (kc = 0; kc < 6; kc = kc + 1) begin
         if (route_ff[`PXM_CNT_MSB:`PXM_CNT_LSB] <= `PXM_CNT_MAX &&
             kc < route_ff[`PXM_CNT_MSB:`PXM_CNT_LSB]) begin
            o_compare_channel_route[kc] = 1'b1;
         end
      end
   end

   assign o_route_skip                       = skip_ff;
   assign o_route_matrix_enable              = route_ff[`PXM_BIT_XBAR_EN];
   assign o_second_timer_input_route_enable  = route_ff[`PXM_BIT_T1_EN];
   assign o_first_timer_input_route_enable   = route_ff[`PXM_BIT_T0_EN];
   assign o_counter_clock_input_route_enable = route_ff[`PXM_BIT_ECI_EN];
   assign o_p0_hiz_overdrive                 = overv_ff;
   assign o_match_irq = o_match_pending & i_match_interrupt_enable;
   assign o_osc_wake  = o_port_match;

endmodule // pxm_port_core

// >>> sim/pxm_port_properties.sv
// concurrent checks on the port block, bound to its top module
`include "pxm_defs.vh"
module pxm_port_chk #(
   parameter NPIN = 16                 // pins of both ports
) (
   // clock, reset and register bus
   input wire            i_ref_clk, i_rst_b, i_sfr_wr, i_sfr_rd,
   input wire [7:0]      i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_p0_hiz_overdrive,
   // pads and crossbar
   input wire [NPIN-1:0] i_xbar_two_wire, o_pin_out, o_pin_oe, o_pin_pullup_en,
   input wire [NPIN-1:0] o_pin_digital_en, o_route_skip,
   input wire            o_route_matrix_enable, o_second_timer_input_route_enable,
   input wire            o_first_timer_input_route_enable, o_counter_clock_input_route_enable,
   input wire [5:0]      o_compare_channel_route,
   // match event
   input wire            i_match_interrupt_enable, o_port_match, o_match_pending,
   input wire            o_match_irq, o_osc_wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // byte write to the second route register
   wire wr_rb = i_sfr_wr && (i_sfr_addr == `PXM_ADR_ROUTE_B);
   a_route_enable: assert property (
      wr_rb |=> o_route_matrix_enable == $past(i_sfr_wdata[6])) else $error("route enable lost");
   a_timer_routes: assert property (
      wr_rb |=> {o_second_timer_input_route_enable, o_first_timer_input_route_enable,
      o_counter_clock_input_route_enable} == $past(i_sfr_wdata[5:3])) else $error("input routes");
   a_channel_count: assert property (
      wr_rb |=> o_compare_channel_route == (($past(i_sfr_wdata[2:0]) == 3'h7) ? 6'h00 :
      ((6'h01 << $past(i_sfr_wdata[2:0])) - 6'h01))) else $error("channel route wrong");
   a_xbar_off_drv: assert property (
      !o_route_matrix_enable |=> o_pin_oe == '0) else $error("driver on with crossbar off");
   a_pullup_gate: assert property (
      (o_pin_pullup_en & (o_pin_oe | ~o_pin_digital_en)) == '0) else $error("pullup on");
   a_analog_drv: assert property (
      (o_pin_oe & ~o_pin_digital_en) == '0) else $error("analog pin driven");
   a_two_wire_od: assert property (
      1'b1 |=> (o_pin_oe & o_pin_out & $past(i_xbar_two_wire)) == '0) else $error("wire high");
   a_pend_on_rise: assert property (
      $rose(o_port_match) |=> o_match_pending) else $error("pending not set");
   a_irq_wake: assert property (
      o_match_irq == (o_match_pending & i_match_interrupt_enable) && o_osc_wake == o_port_match)
      else $error("irq or wake wrong");
   a_rdata_holds: assert property (
      !i_sfr_rd |=> $stable(o_sfr_rdata)) else $error("read data moved");
   a_hiz_write: assert property (
      i_sfr_wr && i_sfr_addr == `PXM_ADR_P0_OVERV |=> o_p0_hiz_overdrive == $past(i_sfr_wdata))
      else $error("overdrive reg");
   a_skip_write: assert property (
      i_sfr_wr && i_sfr_addr == `PXM_ADR_P0_SKIP |=> o_route_skip[7:0] == $past(i_sfr_wdata))
      else $error("skip reg");
endmodule // pxm_port_chk
bind pxm_port_core pxm_port_chk #(.NPIN(NPIN)) u_chk (.i_ref_clk, .i_rst_b, .i_sfr_wr,
   .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_p0_hiz_overdrive, .i_xbar_two_wire,
   .o_pin_out, .o_pin_oe, .o_pin_pullup_en, .o_pin_digital_en, .o_route_skip,
   .o_route_matrix_enable, .o_second_timer_input_route_enable,
   .o_first_timer_input_route_enable, .o_counter_clock_input_route_enable,
   .o_compare_channel_route, .i_match_interrupt_enable, .o_port_match, .o_match_pending,
   .o_match_irq, .o_osc_wake);

// >>> sim/pxm_pad_model.sv
// pad model: wired level of each pin as the receivers see it
module pxm_pad_model #(
   parameter NPIN = 16                 // pins of both ports
) (
   input  wire            i_ref_clk,   // system clock
   input  wire [NPIN-1:0] i_out, i_oe, i_pullup, // pad controls
   input  wire [NPIN-1:0] i_ext_low,   // outside device pulling low
   output wire [NPIN-1:0] o_level      // resolved wire level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [NPIN-1:0] float_ff = '0;     // undriven pins wander, never hold
   // toggle so an open pin never looks like a clean level
   always @(posedge i_ref_clk) float_ff <= ~float_ff;
   // driver, else pullup, else floating; outside pull-down wins on every pin, driven or open
   assign o_level = ~i_ext_low & ((i_oe & i_out) | (~i_oe & (i_pullup | float_ff)));
endmodule // pxm_pad_model

// >>> sim/testbench.sv
// self-checking bench of the port block over its register bus
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_b = 1'b0;          // clock, reset
   logic [7:0]  addr = 8'h00, wdata = 8'h00;       // register bus
   logic        wr = 1'b0, bwr = 1'b0, bval = 1'b0, rd = 1'b0, rmw = 1'b0;
   logic [2:0]  bsel = 3'h0;                       // bit number
   logic [15:0] ext_low = 16'h0000, claim = 16'h0000, xdata = 16'h0000, twow = 16'h0000;
   logic        mie = 1'b0, pclr = 1'b0;           // match interrupt controls
   wire  [7:0]  rdata, hiz;
   wire  [15:0] pin, pout, poe, ppu, pden, skip;
   wire         xen, t1e, t0e, counter_clock_input_route_enable, pm, pp, irq, wake;
   wire  [5:0]  chan;
   int          err_count = 0, n_checks = 0;
   // map and reset values, last entry unmapped
   localparam logic [7:0] ADR [11] = '{8'h80, 8'h90, 8'hA4, 8'hB0, 8'hC7, 8'hD4, 8'hD7,
      8'hE2, 8'hF1, 8'hF2, 8'h81};
   localparam logic [7:0] RSV [11] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'hFF, 8'hFF, 8'h00};
   pxm_port_core #(.NPIN(16)) u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_sfr_addr(addr),
      .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel),
      .i_sfr_bit_val(bval), .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata),
      .i_pin(pin), .o_pin_out(pout), .o_pin_oe(poe), .o_pin_pullup_en(ppu),
      .o_pin_digital_en(pden), .o_p0_hiz_overdrive(hiz), .i_xbar_claim(claim),
      .i_xbar_data(xdata), .i_xbar_two_wire(twow), .o_route_skip(skip),
      .o_route_matrix_enable(xen), .o_second_timer_input_route_enable(t1e),
      .o_first_timer_input_route_enable(t0e), .o_counter_clock_input_route_enable(counter_clock_input_route_enable),
      .o_compare_channel_route(chan), .i_match_interrupt_enable(mie),
      .i_match_pending_clear(pclr), .o_port_match(pm), .o_match_pending(pp),
      .o_match_irq(irq), .o_osc_wake(wake));
   pxm_pad_model #(.NPIN(16)) u_pads (.i_ref_clk(clk), .i_out(pout), .i_oe(poe),
      .i_pullup(ppu), .i_ext_low(ext_low), .o_level(pin));
   // 50 ns period
   initial forever #25 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // byte or bit write, returns once the pads have followed
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
      input logic [2:0] s = 3'h0);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= ~b;
      bwr <= b;
      bsel <= s;
      bval <= d[0];
      @(posedge clk);
      wr <= 1'b0;
      bwr <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rmw <= m;
      @(posedge clk);
      rd <= 1'b0;
      rmw <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, e});
   endtask
   // bounded wait for the match level
   task automatic wait_pm(input logic e);
      for (int i = 0; i < 12 && pm !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk({15'h0000, pm}, {15'h0000, e});
      if (pm !== e) print_verdict();
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 11; k++) rd_chk(ADR[k], 1'b0, RSV[k]);
      for (int k = 2; k < 10; k++) begin
         wr_reg(ADR[k], 8'h5A ^ 8'(k));
         rd_chk(ADR[k], 1'b0, 8'h5A ^ 8'(k));
      end
      for (int k = 2; k < 10; k++) wr_reg(ADR[k], RSV[k]);
      // overdrive and skip registers reach their outputs
      wr_reg(8'hB0, 8'hA5);
      wr_reg(8'hD4, 8'h3C);
      chk({hiz, skip[7:0]}, 16'hA53C);
      wr_reg(8'hB0, 8'h00);
      wr_reg(8'hD4, 8'h00);
      // every channel count, each with the timer route pattern of the same value
      for (int c = 0; c < 8; c++) begin
         wr_reg(8'hE2, 8'((c << 3) | c));
         chk({10'h000, chan}, (c == 7) ? 16'h0000 : 16'((1 << c) - 1));
         chk({13'h0000, t1e, t0e, counter_clock_input_route_enable}, 16'(c));
      end
      wr_reg(8'hE2, 8'h40);
      chk({15'h0000, xen}, 16'h0001);
      wr_reg(8'hA4, 8'h0F);
      @(posedge clk);
      ext_low <= 16'h0030;
      wr_reg(8'h80, 8'hF5);
      repeat (6) @(posedge clk);
      rd_chk(8'h80, 1'b0, 8'hC5);
      rd_chk(8'h80, 1'b1, 8'hF5);
      chk({poe[7:0], ppu[7:0]}, 16'h0FF0);
      wr_reg(8'h80, 8'h01, 1'b1, 3'h1);
      rd_chk(8'h80, 1'b1, 8'hF7);
      wr_reg(8'hA4, 8'h01, 1'b1, 3'h7);
      rd_chk(8'hA4, 1'b0, 8'h0F);
      wr_reg(8'hD4, 8'h01);
      wr_reg(8'h80, 8'h01, 1'b1, 3'h0);
      wr_reg(8'hF1, 8'hFE);
      repeat (6) @(posedge clk);
      rd_chk(8'h80, 1'b0, 8'hC6);
      chk({13'h0000, poe[0], ppu[0], pden[0]}, 16'h0000);
      @(posedge clk);
      twow <= 16'h0002;
      claim <= 16'h0004;
      repeat (2) @(posedge clk);
      #1;
      chk({13'h0000, poe[1], pout[2], poe[2]}, 16'h0001);
      @(posedge clk);
      twow <= 16'h0000;
      claim <= 16'h0000;
      repeat (8) @(posedge clk);
      #1;
      chk({15'h0000, pm}, 16'h0000);
      wr_reg(8'hC7, 8'h30);
      wait_pm(1'b1);
      @(posedge clk);
      mie <= 1'b1;
      @(posedge clk);
      #1;
      chk({13'h0000, pp, irq, wake}, 16'h0007);
      @(posedge clk);
      pclr <= 1'b1;
      @(posedge clk);
      pclr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({14'h0000, pp, irq}, 16'h0000);
      @(posedge clk);
      ext_low <= 16'h0000;
      wait_pm(1'b0);
      wr_reg(8'hBF, 8'h01);
      @(posedge clk);
      ext_low <= 16'h0100;
      wait_pm(1'b1);
      wr_reg(8'hE2, 8'h80);
      chk(poe | ppu, 16'h0000);
      print_verdict();
   end
endmodule // testbench
